// [hw/rvc_capture_window.sv]
// raw blanking-interval capture window: registers, line and sample selection
//
// Functional notes
// R1: the 10-bit stop count is the low stop register as bits 7..0 and its high register bits 1..0 as bits 9..8.
// R2: sampling on a line ends once the horizontal count reaches the stop count, in two-clock steps from line sync.
// R3: the low eight stop count bits come out of reset as 4A hex.
// R4: the upper two stop count bits reset to 11 binary and the other bits of that register read zero.
// R5: a 19-bit line mask is held over three registers, and a one enables capture of the matching line.
// R6: the mask resets to FE hex low, 1F hex middle, and zero in the top three bits and reserved bits.
// R7: in the 525-line standard mask bit n picks line 9+n of the odd field and 272+n of the even field.
// R8: in the 625-line standard mask bit n picks line 5+n of the odd field and 318+n of the even field.
// R9: sampling starts at an 8-bit start count in two-clock steps from line sync, resetting to 7A hex.
// R10: with the all-lines bit set every line of an enabled field is captured, else only masked lines.
// R11: odd and even field enable bits gate capture, so a disabled field gives no lines at all.
// R12: a horizontal counter restarts at each line sync, steps every two clocks, and sampling runs between start and stop.
`timescale 1ns/10ps
module rvc_capture_window (
	input  wire logic                            ref_clk,
	input  wire logic                            rst,
	input  wire logic                            clkEn,
	input  wire logic [7:0]                      regAddr,
	input  wire logic [7:0]                      regWrData,
	input  wire logic                            regWr,
	input  wire logic                            regRd,
	output logic      [7:0]                      regRdData,
	input  wire logic                            lineSyncStart,
	input  wire logic                            fieldEven,
	input  wire logic                            standard625,
	input  wire logic [rvc_pkg::LINE_W-1:0]      lineNum,
	input  wire logic                            sampleValid,
	input  wire logic [rvc_pkg::DATA_W-1:0]      sampleData,
	output logic                                 sampleReady,
	output logic                                 rawValid,
	output logic      [rvc_pkg::DATA_W-1:0]      rawData,
	input  wire logic                            rawReady
);
	// register state
	logic [2:0]                  ctrl_q, ctrl_d;
	logic [7:0]                  start_q, start_d;
	logic [7:0]                  stopLow_q, stopLow_d;
	logic [1:0]                  stopHigh_q, stopHigh_d;
	logic [7:0]                  maskLow_q, maskLow_d;
	logic [7:0]                  maskMid_q, maskMid_d;
	logic [2:0]                  maskHigh_q, maskHigh_d;
	logic                        ovf_q, ovf_d;
	logic [7:0]                  rdData_q, rdData_d;

	// horizontal state
	logic [rvc_pkg::HPOS_W-1:0]  hPos_q, hPos_d;
	logic                        phase_q, phase_d;

	// push stage into the buffer
	logic                        wrValid_q, wrValid_d;
	logic [rvc_pkg::DATA_W-1:0]  wrData_q, wrData_d;

	// derived values
	logic [rvc_pkg::HPOS_W-1:0]  stopCount;
	logic [rvc_pkg::MASK_W-1:0]  lineMask;
	logic [rvc_pkg::LINE_W-1:0]  lineBase;
	logic                        inWindow;
	logic                        fieldEn;
	logic                        maskHit;
	logic                        lineCapture;
	logic                        ovfEvent;

	rvc_stream_if pushIf ();

	// cascaded stop count and the full line mask
	assign stopCount = {stopHigh_q, stopLow_q}; // [R1]
	assign lineMask  = {maskHigh_q, maskMid_q, maskLow_q}; // [R5]

	// window open from the start count until the stop count is reached
	assign inWindow = (hPos_q >= {2'h0, start_q}) && (hPos_q < stopCount); // [R2] [R9] [R12]

	// first line of the field by standard and field parity
	always_comb begin
		if (standard625) begin
			lineBase = fieldEven ? rvc_pkg::PAL_EVEN_BASE : rvc_pkg::PAL_ODD_BASE; // [R8]
		end else begin
			lineBase = fieldEven ? rvc_pkg::NTSC_EVEN_BASE : rvc_pkg::NTSC_ODD_BASE; // [R7]
		end
	end

	rvc_line_sel uLineSel (
		.lineNum  (lineNum),
		.lineBase (lineBase),
		.lineMask (lineMask),
		.maskHit  (maskHit)
	);

	// field gating and the all-lines override
	assign fieldEn     = fieldEven ? ctrl_q[rvc_pkg::CTRL_EVEN_BIT]
	                               : ctrl_q[rvc_pkg::CTRL_ODD_BIT]; // [R11]
	assign lineCapture = fieldEn && (ctrl_q[rvc_pkg::CTRL_ALL_BIT] || maskHit); // [R10] [R11]

	// a word is lost when the buffer refuses the pushed word
	assign ovfEvent = wrValid_q && !pushIf.ready;

	// register file next values, write decode and read mux
	always_comb begin
		ctrl_d     = ctrl_q;
		start_d    = start_q;
		stopLow_d  = stopLow_q;
		stopHigh_d = stopHigh_q;
		maskLow_d  = maskLow_q;
		maskMid_d  = maskMid_q;
		maskHigh_d = maskHigh_q;
		ovf_d      = ovf_q;
		rdData_d   = 8'h00;
		if (regWr) begin
			if (regAddr == rvc_pkg::CTRL_OFS) begin
				ctrl_d = regWrData[2:0];
			end else if (regAddr == rvc_pkg::START_OFS) begin
				start_d = regWrData; // [R9]
			end else if (regAddr == rvc_pkg::STOPL_OFS) begin
				stopLow_d = regWrData; // [R1]
			end else if (regAddr == rvc_pkg::STOPH_OFS) begin
				stopHigh_d = regWrData[1:0]; // [R1]
			end else if (regAddr == rvc_pkg::MASKL_OFS) begin
				maskLow_d = regWrData; // [R5]
			end else if (regAddr == rvc_pkg::MASKM_OFS) begin
				maskMid_d = regWrData; // [R5]
			end else if (regAddr == rvc_pkg::MASKH_OFS) begin
				maskHigh_d = regWrData[2:0]; // [R5]
			end else if (regAddr == rvc_pkg::STAT_OFS) begin
				if (regWrData[rvc_pkg::STAT_OVF_BIT]) begin
					ovf_d = 1'h0;
				end
			end
		end
		if (ovfEvent) begin
			ovf_d = 1'h1; // set wins over a clear in the same cycle
		end
		if (regRd) begin
			if (regAddr == rvc_pkg::CTRL_OFS) begin
				rdData_d = {5'h00, ctrl_q};
			end else if (regAddr == rvc_pkg::START_OFS) begin
				rdData_d = start_q;
			end else if (regAddr == rvc_pkg::STOPL_OFS) begin
				rdData_d = stopLow_q;
			end else if (regAddr == rvc_pkg::STOPH_OFS) begin
				rdData_d = {6'h00, stopHigh_q}; // [R4]
			end else if (regAddr == rvc_pkg::MASKL_OFS) begin
				rdData_d = maskLow_q;
			end else if (regAddr == rvc_pkg::MASKM_OFS) begin
				rdData_d = maskMid_q;
			end else if (regAddr == rvc_pkg::MASKH_OFS) begin
				rdData_d = {5'h00, maskHigh_q}; // [R6]
			end else if (regAddr == rvc_pkg::STAT_OFS) begin
				rdData_d = 8'h00;
				rdData_d[rvc_pkg::STAT_WIN_BIT]   = inWindow;
				rdData_d[rvc_pkg::STAT_SEL_BIT]   = lineCapture;
				rdData_d[rvc_pkg::STAT_OVF_BIT]   = ovf_q;
				rdData_d[rvc_pkg::STAT_EMPTY_BIT] = !rawValid;
			end else begin
				rdData_d = 8'h00; // unmapped addresses read zero
			end
		end
	end

	// register file storage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q     <= rvc_pkg::CTRL_RST;
			start_q    <= rvc_pkg::START_RST; // [R9]
			stopLow_q  <= rvc_pkg::STOPL_RST; // [R3]
			stopHigh_q <= rvc_pkg::STOPH_RST; // [R4]
			maskLow_q  <= rvc_pkg::MASKL_RST; // [R6]
			maskMid_q  <= rvc_pkg::MASKM_RST; // [R6]
			maskHigh_q <= rvc_pkg::MASKH_RST; // [R6]
			ovf_q      <= 1'h0;
			rdData_q   <= 8'h00;
		end else if (clkEn) begin
			ctrl_q     <= ctrl_d;
			start_q    <= start_d;
			stopLow_q  <= stopLow_d;
			stopHigh_q <= stopHigh_d;
			maskLow_q  <= maskLow_d;
			maskMid_q  <= maskMid_d;
			maskHigh_q <= maskHigh_d;
			ovf_q      <= ovf_d;
			rdData_q   <= rdData_d;
		end
	end

	assign regRdData = rdData_q;

	// horizontal counter: restart on sync, one step per two clocks, saturate
	always_comb begin
		hPos_d  = hPos_q;
		phase_d = ~phase_q;
		if (lineSyncStart) begin
			hPos_d  = '0; // [R12]
			phase_d = 1'h0;
		end else if ((phase_q == rvc_pkg::STEP_LAST) && (hPos_q != rvc_pkg::HPOS_MAX)) begin
			hPos_d = hPos_q + 10'h001; // [R12]
		end
	end

	// horizontal counter storage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hPos_q  <= '0;
			phase_q <= 1'h0;
		end else if (clkEn) begin
			hPos_q  <= hPos_d;
			phase_q <= phase_d;
		end
	end

	// capture a sample only inside the window on a selected line
	always_comb begin
		wrValid_d = sampleValid && inWindow && lineCapture; // [R2] [R10] [R11]
		wrData_d  = sampleValid ? sampleData : wrData_q;
	end

	// push stage storage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrValid_q <= 1'h0;
			wrData_q  <= '0;
		end else if (clkEn) begin
			wrValid_q <= wrValid_d;
			wrData_q  <= wrData_d;
		end
	end

	assign pushIf.valid = wrValid_q;
	assign pushIf.data  = wrData_q;
	assign sampleReady  = pushIf.ready;

	rvc_fifo #(
		.WIDTH (rvc_pkg::DATA_W),
		.DEPTH (rvc_pkg::FIFO_DEPTH)
	) uFifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clkEn   (clkEn),
		.wr      (pushIf.snk),
		.rdValid (rawValid),
		.rdData  (rawData),
		.rdReady (rawReady)
	);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// register writes, reads and reset values
	stopCat_a: assert property (clkEn && regWr && regAddr == rvc_pkg::STOPH_OFS |=> // [R1]
		stopCount == {$past(regWrData[1:0]), $past(stopLow_q)})
		else $error("stop count high bits not taken from write");

	stopLowWr_a: assert property (clkEn && regWr && regAddr == rvc_pkg::STOPL_OFS |=> // [R1]
		stopCount[7:0] == $past(regWrData))
		else $error("stop count low bits not taken from write");

	stopRst_a: assert property ($past(rst) |-> regRdData == 8'h00 && // [R3] [R4]
		stopCount == {rvc_pkg::STOPH_RST, rvc_pkg::STOPL_RST})
		else $error("stop count reset value wrong");

	stopHighRd_a: assert property (clkEn && regRd && regAddr == rvc_pkg::STOPH_OFS |=> // [R4]
		regRdData[7:2] == 6'h00)
		else $error("reserved stop bits not read as zero");

	maskWr_a: assert property (clkEn && regWr && regAddr == rvc_pkg::MASKH_OFS |=> // [R5]
		lineMask[18:16] == $past(regWrData[2:0]))
		else $error("mask top bits not written");

	maskLowWr_a: assert property (clkEn && regWr && regAddr == rvc_pkg::MASKL_OFS |=> // [R5]
		lineMask[7:0] == $past(regWrData))
		else $error("mask low bits not written");

	maskRst_a: assert property ($past(rst) |-> // [R6]
		lineMask == {rvc_pkg::MASKH_RST, rvc_pkg::MASKM_RST, rvc_pkg::MASKL_RST})
		else $error("line mask reset value wrong");

	maskHighRd_a: assert property (clkEn && regRd && regAddr == rvc_pkg::MASKH_OFS |=> // [R6]
		regRdData[7:3] == 5'h00)
		else $error("reserved mask bits not read as zero");

	startRst_a: assert property ($past(rst) |-> // [R9]
		start_q == rvc_pkg::START_RST)
		else $error("start count reset value wrong");

	// line number to mask bit mapping
	ntscMap_a: assert property (!standard625 && fieldEven && lineNum == 10'h110 |-> // [R7]
		maskHit == lineMask[0])
		else $error("even field line 272 not mapped to mask bit 0");

	ntscOddLow_a: assert property (!standard625 && !fieldEven && lineNum == 10'h009 |-> // [R7]
		maskHit == lineMask[0])
		else $error("odd field line 9 not mapped to mask bit 0");

	ntscOddHigh_a: assert property (!standard625 && !fieldEven && lineNum == 10'h01B |-> // [R7]
		maskHit == lineMask[18])
		else $error("odd field line 27 not mapped to mask bit 18");

	palMap_a: assert property (standard625 && !fieldEven && lineNum == 10'h017 |-> // [R8]
		maskHit == lineMask[18])
		else $error("odd field line 23 not mapped to mask bit 18");

	palOddLow_a: assert property (standard625 && !fieldEven && lineNum == 10'h005 |-> // [R8]
		maskHit == lineMask[0])
		else $error("odd field line 5 not mapped to mask bit 0");

	palEvenLow_a: assert property (standard625 && fieldEven && lineNum == 10'h13E |-> // [R8]
		maskHit == lineMask[0])
		else $error("even field line 318 not mapped to mask bit 0");

	// sample gating by window, mask and field enables
	stopEnd_a: assert property (clkEn && sampleValid && hPos_q >= stopCount |=> // [R2]
		!wrValid_q)
		else $error("sample pushed at or past stop count");

	startGate_a: assert property (clkEn && sampleValid && hPos_q < {2'h0, start_q} |=> // [R9]
		!wrValid_q)
		else $error("sample pushed before start count");

	allLines_a: assert property (clkEn && sampleValid && inWindow && fieldEn && // [R10]
		ctrl_q[rvc_pkg::CTRL_ALL_BIT] |=> wrValid_q)
		else $error("all-lines mode dropped a sample");

	maskOff_a: assert property (clkEn && fieldEn && !maskHit && // [R10]
		!ctrl_q[rvc_pkg::CTRL_ALL_BIT] |=> !wrValid_q)
		else $error("unmasked line produced a sample");

	fieldGate_a: assert property (clkEn && !fieldEn |=> // [R11]
		!wrValid_q)
		else $error("disabled field produced a sample");

	// horizontal counter restart and stepping
	hRestart_a: assert property (clkEn && lineSyncStart |=> // [R12]
		hPos_q == 10'h000 && !phase_q)
		else $error("horizontal count not restarted at line sync");

	hStep_a: assert property (clkEn && !lineSyncStart && phase_q && // [R12]
		hPos_q != rvc_pkg::HPOS_MAX |=> hPos_q == $past(hPos_q) + 10'h001)
		else $error("horizontal count did not step on second clock");

	hHold_a: assert property (clkEn && !lineSyncStart && !phase_q |=> // [R12]
		hPos_q == $past(hPos_q))
		else $error("horizontal count stepped on first clock");

	// clock enable freeze and the sticky overflow flag
	frozenState_a: assert property (!clkEn |=>
		$stable(hPos_q) && $stable(lineMask) && $stable(start_q))
		else $error("state changed while clock enable low");

	ovfSet_a: assert property (clkEn && ovfEvent |=>
		ovf_q)
		else $error("overflow flag lost");

	ovfClr_a: assert property (clkEn && regWr && regAddr == rvc_pkg::STAT_OFS && !ovfEvent &&
		regWrData[rvc_pkg::STAT_OVF_BIT] |=> !ovf_q)
		else $error("overflow flag not cleared by write");
endmodule

// [hw/rvc_fifo.sv]
// flip-flop word buffer with valid/ready on both sides
`timescale 1ns/10ps
module rvc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	rvc_stream_if.snk             wr,
	output logic                  rdValid,
	output logic [WIDTH-1:0]      rdData,
	input  wire logic             rdReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW:0]      wrPtr_q, wrPtr_d;
	logic [AW:0]      rdPtr_q, rdPtr_d;
	logic             full;
	logic             push;
	logic             pop;

	// honest full and empty from pointers with a wrap bit
	assign full    = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
	assign rdValid = (wrPtr_q != rdPtr_q);
	assign wr.ready = !full;
	assign push    = wr.valid && !full;
	assign pop     = rdValid && rdReady;
	assign rdData  = mem_q[rdPtr_q[AW-1:0]];

	// next pointers
	always_comb begin
		wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
	end

	// next value of each entry
	for (genvar i = 0; i < DEPTH; i++) begin : gEntry
		always_comb begin
			mem_d[i] = (push && (wrPtr_q[AW-1:0] == AW'(i))) ? wr.data : mem_q[i];
		end
	end

	// state registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (clkEn) begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= mem_d[i];
			end
		end
	end
endmodule

// [hw/rvc_line_sel.sv]
// maps the current line onto the 19-bit line mask
`timescale 1ns/10ps
module rvc_line_sel (
	input  wire logic [rvc_pkg::LINE_W-1:0] lineNum,
	input  wire logic [rvc_pkg::LINE_W-1:0] lineBase,
	input  wire logic [rvc_pkg::MASK_W-1:0] lineMask,
	output logic                            maskHit
);
	logic [rvc_pkg::MASK_W-1:0] hitVec;

	// mask bit n selects line base plus n
	for (genvar n = 0; n < rvc_pkg::MASK_W; n++) begin : gBit
		assign hitVec[n] = lineMask[n] && (lineNum == lineBase + rvc_pkg::LINE_W'(n)); // [R5]
	end

	assign maskHit = |hitVec;
endmodule

// [hw/rvc_pkg.sv]
// constants shared by the raw capture window block
package rvc_pkg;
	// register offsets
	localparam logic [7:0] CTRL_OFS  = 8'h11;
	localparam logic [7:0] START_OFS = 8'h12;
	localparam logic [7:0] STOPL_OFS = 8'h13;
	localparam logic [7:0] STOPH_OFS = 8'h14;
	localparam logic [7:0] MASKL_OFS = 8'h15;
	localparam logic [7:0] MASKM_OFS = 8'h16;
	localparam logic [7:0] MASKH_OFS = 8'h17;
	localparam logic [7:0] STAT_OFS  = 8'h20;

	// widths and depths
	localparam int DATA_W     = 8;
	localparam int HPOS_W     = 10;
	localparam int LINE_W     = 10;
	localparam int MASK_W     = 19;
	localparam int FIFO_DEPTH = 16;

	// reset values
	localparam logic [2:0] CTRL_RST  = 3'h0;
	localparam logic [7:0] START_RST = 8'h7A;
	localparam logic [7:0] STOPL_RST = 8'h4A;
	localparam logic [1:0] STOPH_RST = 2'h3;
	localparam logic [7:0] MASKL_RST = 8'hFE;
	localparam logic [7:0] MASKM_RST = 8'h1F;
	localparam logic [2:0] MASKH_RST = 3'h0;

	// control and status field positions
	localparam int CTRL_ODD_BIT   = 0;
	localparam int CTRL_EVEN_BIT  = 1;
	localparam int CTRL_ALL_BIT   = 2;
	localparam int STAT_WIN_BIT   = 0;
	localparam int STAT_SEL_BIT   = 1;
	localparam int STAT_OVF_BIT   = 2;
	localparam int STAT_EMPTY_BIT = 3;

	// first line of each field that mask bit 0 selects
	localparam logic [9:0] NTSC_ODD_BASE  = 10'h009;
	localparam logic [9:0] NTSC_EVEN_BASE = 10'h110;
	localparam logic [9:0] PAL_ODD_BASE   = 10'h005;
	localparam logic [9:0] PAL_EVEN_BASE  = 10'h13E;

	// horizontal counter timing: one step per two sample clocks
	localparam logic       STEP_LAST = 1'h1;
	localparam logic [9:0] HPOS_MAX  = 10'h3FF;
endpackage

// [hw/rvc_stream_if.sv]
// valid/ready word stream between the window logic and the buffer
`timescale 1ns/10ps
interface rvc_stream_if;
	logic                       valid;
	logic                       ready;
	logic [rvc_pkg::DATA_W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [verif/rvc_video_model.sv]
// video line source standing in for the decoder front end
`timescale 1ns/10ps
module rvc_video_model (
	input  wire logic       ref_clk,
	output logic            lineSyncStart,
	output logic            fieldEven,
	output logic            standard625,
	output logic [9:0]      lineNum,
	output logic            sampleValid,
	output logic [7:0]      sampleData
);
	// idle levels at time zero
	initial begin
		lineSyncStart = 1'b0;
		fieldEven = 1'b0;
		standard625 = 1'b0;
		lineNum = 10'h000;
		sampleValid = 1'b0;
		sampleData = 8'h00;
	end

	// one line: sync pulse, then one sample per clock numbered from zero
	task automatic sendLine(input logic [9:0] ln, input logic ev, input logic s625, input int len);
		int i;
		@(posedge ref_clk);
		lineNum <= ln;
		fieldEven <= ev;
		standard625 <= s625;
		lineSyncStart <= 1'b1;
		for (i = 0; i < len; i++) begin
			@(posedge ref_clk);
			lineSyncStart <= 1'b0;
			sampleValid <= 1'b1;
			sampleData <= i[7:0];
		end
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		sampleData <= 8'hC3;  // idle data is not left at the last sample
	endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for the raw capture window
`timescale 1ns/10ps
module testbench;
	logic        ref_clk;
	logic        rst;
	logic        clkEn;
	logic [7:0]  regAddr;
	logic [7:0]  regWrData;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regRdData;
	logic        lineSyncStart;
	logic        fieldEven;
	logic        standard625;
	logic [9:0]  lineNum;
	logic        sampleValid;
	logic [7:0]  sampleData;
	logic        sampleReady;
	logic        rawValid;
	logic [7:0]  rawData;
	logic        rawReady;
	int          numErrors;
	int          compares;
	int          s;
	int          f;
	int          k;
	int          n;
	logic [9:0]  b;
	logic [7:0]  rd;
	logic [7:0]  popQ[$];
	logic [7:0]  rstVals[7] = '{8'h00, 8'h7A, 8'h4A, 8'h03, 8'hFE, 8'h1F, 8'h00};

	rvc_capture_window u_dut (
		.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.lineSyncStart(lineSyncStart), .fieldEven(fieldEven), .standard625(standard625),
		.lineNum(lineNum), .sampleValid(sampleValid), .sampleData(sampleData),
		.sampleReady(sampleReady), .rawValid(rawValid), .rawData(rawData), .rawReady(rawReady)
	);

	rvc_video_model u_model (
		.ref_clk(ref_clk), .lineSyncStart(lineSyncStart), .fieldEven(fieldEven),
		.standard625(standard625), .lineNum(lineNum), .sampleValid(sampleValid),
		.sampleData(sampleData)
	);

	// clock at 40 MHz
	always #12.5 ref_clk = ~ref_clk;

	// collect every word popped at the next edge, looked at mid-cycle where settled
	always @(negedge ref_clk) begin
		if (rawValid === 1'b1 && rawReady === 1'b1)
			popQ.push_back(rawData);
	end

	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic testDone;
		$display("errors %0d compares %0d", numErrors, compares);
		if (numErrors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic regRead(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	task automatic setWin(input logic [7:0] st, input logic [9:0] sp);
		regWrite(8'h12, st);
		regWrite(8'h13, sp[7:0]);
		regWrite(8'h14, {6'h00, sp[9:8]});
	endtask

	task automatic setMask(input logic [18:0] m);
		regWrite(8'h15, m[7:0]);
		regWrite(8'h16, m[15:8]);
		regWrite(8'h17, {5'h00, m[18:16]});
	endtask

	// downstream stalls during the line, then drains the buffer
	task automatic drain;
		@(posedge ref_clk);
		rawReady <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rawReady <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic runLine(input logic [9:0] ln, input logic ev, input logic s625, input int expN);
		int i;
		popQ.delete();
		u_model.sendLine(ln, ev, s625, 20);
		drain();
		cmp(popQ.size(), expN);
		// with a start count of 2 the first word kept is sample 4
		if (expN > 0)
			cmp(32'(popQ[0]), 32'h04);
		for (i = 1; i < popQ.size(); i++)
			cmp(32'(popQ[i]), 32'(popQ[i-1] + 8'h01));
	endtask

	function automatic logic [9:0] lineBase(input logic s625, input logic ev);
		if (s625)
			lineBase = ev ? 10'h13E : 10'h005;
		else
			lineBase = ev ? 10'h110 : 10'h009;
	endfunction

	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		numErrors++;
		testDone();
	end

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		clkEn = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		rawReady = 1'b0;
		numErrors = 0;
		compares = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		// reset values, reserved bits, unmapped place
		for (k = 0; k < 7; k++) begin
			regRead(8'h11 + k[7:0], rd);
			cmp(32'(rd), 32'(rstVals[k]));
		end
		regRead(8'h30, rd);
		cmp(32'(rd), 32'h0);
		regWrite(8'h14, 8'hFF);
		regRead(8'h14, rd);
		cmp(32'(rd), 32'h03);
		regWrite(8'h17, 8'hFF);
		regRead(8'h17, rd);
		cmp(32'(rd), 32'h07);
		// a strobe while frozen is ignored
		@(posedge ref_clk);
		clkEn <= 1'b0;
		regWrite(8'h12, 8'h33);
		clkEn <= 1'b1;
		regRead(8'h12, rd);
		cmp(32'(rd), 32'h7A);
		// single mask bits at both ends, every standard and field
		setWin(8'h02, 10'h006);
		regWrite(8'h11, 8'h03);
		for (s = 0; s < 2; s++)
			for (f = 0; f < 2; f++)
				for (k = 0; k < 2; k++) begin
					n = k ? 18 : 0;
					b = lineBase(s[0], f[0]) + n[9:0];
					setMask(19'h00001 << n);
					runLine(b, f[0], s[0], 8);
					runLine(b - 10'h001, f[0], s[0], 0);
					runLine(b + 10'h001, f[0], s[0], 0);
				end
		// all lines and field gating
		setMask(19'h00000);
		regWrite(8'h11, 8'h07);
		runLine(10'h064, 1'b0, 1'b0, 8);
		regWrite(8'h11, 8'h06);
		runLine(10'h064, 1'b0, 1'b0, 0);
		runLine(10'h064, 1'b1, 1'b0, 8);
		regWrite(8'h11, 8'h05);
		runLine(10'h064, 1'b1, 1'b0, 0);
		// window straddling the upper stop bits: counts 254..256
		regWrite(8'h11, 8'h07);
		setWin(8'hFE, 10'h101);
		popQ.delete();
		u_model.sendLine(10'h064, 1'b0, 1'b0, 530);
		drain();
		cmp(popQ.size(), 6);
		// buffer overrun with a stalled sink
		setWin(8'h00, 10'h014);
		popQ.delete();
		u_model.sendLine(10'h064, 1'b0, 1'b0, 50);
		cmp(32'(sampleReady), 32'h0);
		regRead(8'h20, rd);
		cmp(32'(rd[2]), 32'h1);
		drain();
		cmp(popQ.size(), 16);
		regRead(8'h20, rd);
		cmp(32'(rd[3]), 32'h1);
		cmp(32'(rd[1]), 32'h1);
		cmp(32'(rd[0]), 32'h0);
		regWrite(8'h20, 8'h04);
		regRead(8'h20, rd);
		cmp(32'(rd[2]), 32'h0);
		testDone();
	end
endmodule
